/* rspf_bit_sync.sv */
/*
  recovered bit clock and cleaned data for continuous and packet receive.
  assumes raw demodulator bits on sys_clk and a half bit period in cycles, less one.
*/
`timescale 1ns/1ps
`default_nettype none
module rspf_bit_sync (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [7:0] half_period,
  input  wire logic       raw_bit,
  output logic            bit_clk,
  output logic            bit_data
);
  import rspf_pkg::*;
  logic [7:0] cnt;
  logic       raw_q;

  // phase restarts on every raw transition, so the clock locks to the data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt     <= 8'h00;
      raw_q   <= 1'b0;
      bit_clk <= 1'b0;
    end else if (!enable) begin
      cnt     <= 8'h00;
      raw_q   <= raw_bit;
      bit_clk <= 1'b0;
    end else begin
      raw_q <= raw_bit;
      if (raw_q != raw_bit) begin
        cnt     <= 8'h00;
        bit_clk <= 1'b0;
      end else if (cnt >= half_period) begin
        cnt     <= 8'h00;
        bit_clk <= ~bit_clk;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // data moves only as the clock falls, so it is stable at the rising edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_data <= 1'b0;
    end else if (enable && bit_clk && cnt >= half_period && raw_q == raw_bit) begin
      bit_data <= raw_q;
    end
  end

  chk_data_on_fall: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(bit_data) |-> $past(bit_clk) && !bit_clk)
    else $error("bit data changed away from a falling clock");
endmodule : rspf_bit_sync
`default_nettype wire

/* rspf_consts.svh */
/*
  constants for the radio status pin mux and packet format checker:
  mode and mapping codes, frame limits.
  assumes inclusion by the package and by the pin mux.
*/
// Function
// - continuous mode maps pins by code and mode
// - packet mode maps pins by packet table
// - packet rx data only between ready edges
// - continuous data passes directly over pin2
// - continuous tx drives clock, samples rising edge
// - no bit synchronizer: raw data, no clock
// - synchronizer: clean data, fall change, rise capture
// - packet mode data goes through queue only; packet rx data also shows on pin2 and pin5 at code 01
// - packet handler does framing, crc, whitening, crypto
// - packet mode forces bit synchronizer on
// - queue access allowed in sleep and standby
// - format 0, nonzero length means fixed framing
// - fixed payload 255 max, aes 64 or 65
// - fixed length counts message plus address, min 1
// - format 1 means variable framing
// - length byte excludes itself, aes limits apply
// - variable payload holds at least two bytes
// - frame order preamble, sync, length, address, data
// - format 0, zero length means unlimited framing
`ifndef RSPF_CONSTS_SVH
`define RSPF_CONSTS_SVH
`define RSPF_MODE_SLEEP   3'h0
`define RSPF_MODE_STDBY   3'h1
`define RSPF_MODE_FS      3'h2
`define RSPF_MODE_TX      3'h3
`define RSPF_MODE_RX      3'h4
`define RSPF_MAP_00       2'h0
`define RSPF_MAP_01       2'h1
`define RSPF_MAP_10       2'h2
`define RSPF_MAP_11       2'h3
`define RSPF_LEN_MAX      8'hff
`define RSPF_AES_MSG_MAX  8'h40
`define RSPF_AES_FIX_ADR  8'h41
`define RSPF_AES_VAR_ADR  8'h42
`define RSPF_VAR_MIN      8'h02
`define RSPF_FIX_MIN      8'h01
`endif

/* rspf_mcu_model.sv */
/* controller model on the pin side: drives pin2 in continuous tx.
   assumes pin1 carries the device bit clock. */
`timescale 1ns/1ps
`default_nettype none
module rspf_mcu_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_pin,
  input  wire logic dev_oe,
  input  wire logic dev_pin,
  output logic      tx_bit,
  output logic      pin2_wire
);
  logic clk_d;
  // new bit just after a falling edge, far from the rising-edge sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_d  <= 1'b0;
      tx_bit <= 1'b0;
    end else begin
      clk_d <= clk_pin;
      if (clk_d && !clk_pin) tx_bit <= 1'($urandom);
    end
  end
  // released while the device drives the pin
  assign pin2_wire = dev_oe ? dev_pin : tx_bit;
endmodule : rspf_mcu_model
`default_nettype wire

/* rspf_pin_mux.sv */
/*
  status pin mux, continuous data path and frame format decode.
  assumes status from the radio core on sys_clk and the link data pin
  from the controller, which is not on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rspf_consts.svh"
module rspf_pin_mux (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire rspf_pkg::rspf_mode_t     op_mode,
  input  wire logic                     packet_mode,
  input  wire logic                     bit_sync_en,
  input  wire logic [7:0]               bit_half_period,
  input  wire logic [11:0]              pin_map,
  input  wire rspf_pkg::rspf_status_t   status,
  input  wire rspf_pkg::rspf_frame_cfg_t frame_cfg,
  input  wire logic                     demod_bit,
  input  wire logic                     tx_bit_clk,
  input  wire logic                     gp_pin_2_in,
  input  wire logic                     queue_wr_req,
  input  wire logic                     queue_rd_req,
  output logic [5:0]                    gp_pin_out,
  output logic                          gp_pin_2_oe,
  output logic                          mod_bit,
  output logic                          mod_bit_valid,
  output logic                          queue_wr_ok,
  output logic                          queue_rd_ok,
  output logic                          handler_active,
  output logic                          bit_sync_active,
  output rspf_pkg::rspf_fmt_t           frame_fmt,
  output logic                          frame_has_len_byte,
  output logic                          frame_cfg_ok
);
  import rspf_pkg::*;

  logic       s_pin2_a;
  logic       s_pin2;
  logic       rx_gate;
  logic       rxr_q;
  logic       pr_q;
  logic       rec_clk;
  logic       rec_data;
  logic       tx_clk_q;
  logic       next_mod_bit;
  logic [5:0] next_pins;
  logic       rx_data_sel;
  logic       bs_on;

  // packet mode overrides the synchronizer enable
  assign bs_on = packet_mode | bit_sync_en;
  assign bit_sync_active = bs_on && op_mode == RSPF_RX;
  // framing, queue and handler only live in packet mode
  assign handler_active = packet_mode;
  // queue access stays open in sleep and standby as well as active modes
  assign queue_wr_ok = packet_mode & queue_wr_req;
  assign queue_rd_ok = packet_mode & queue_rd_req;

  rspf_bit_sync u_bit_sync (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .enable      (bit_sync_active),
    .half_period (bit_half_period),
    .raw_bit     (demod_bit),
    .bit_clk     (rec_clk),
    .bit_data    (rec_data)
  );

  // the data pin is a foreign-domain input: two flops before any use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_pin2_a <= 1'b0;
      s_pin2   <= 1'b0;
    end else begin
      s_pin2_a <= gp_pin_2_in;
      s_pin2   <= s_pin2_a;
    end
  end

  // transmit sample on the rising edge of the clock we drive out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_clk_q      <= 1'b0;
      mod_bit       <= 1'b0;
      mod_bit_valid <= 1'b0;
    end else begin
      tx_clk_q      <= tx_bit_clk;
      mod_bit_valid <= 1'b0;
      if (!packet_mode && op_mode == RSPF_TX && tx_bit_clk && !tx_clk_q) begin
        mod_bit       <= next_mod_bit;
        mod_bit_valid <= 1'b1;
      end
    end
  end
  // the controller has had half a bit to settle after our falling edge
  assign next_mod_bit = s_pin2;

  // packet receive data window: receiver ready rise opens, payload ready rise shuts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxr_q   <= 1'b0;
      pr_q    <= 1'b0;
      rx_gate <= 1'b0;
    end else begin
      rxr_q <= status.receiver_ready;
      pr_q  <= status.payload_ready_a;
      if (!packet_mode || op_mode != RSPF_RX) begin
        rx_gate <= 1'b0;
      end else if (status.payload_ready_a && !pr_q) begin
        rx_gate <= 1'b0;
      end else if (status.receiver_ready && !rxr_q) begin
        rx_gate <= 1'b1;
      end
    end
  end

  // raw demodulator bits without synchronizer, cleaned bits with it
  assign rx_data_sel = bs_on ? rec_data : demod_bit;

  function automatic logic pick(input logic [1:0] code, input logic s0, input logic s1,
                                input logic s2, input logic s3);
    case (code)
      `RSPF_MAP_00: pick = s0;
      `RSPF_MAP_01: pick = s1;
      `RSPF_MAP_10: pick = s2;
      default:      pick = s3;
    endcase
  endfunction : pick

  // unlisted combinations pass 1'b0, so unused pins sit low
  always_comb begin
    logic [1:0] m0;
    logic [1:0] m1;
    logic [1:0] m2;
    logic [1:0] m3;
    logic [1:0] m4;
    logic [1:0] m5;
    logic       dat;
    logic       dclk;
    m0 = pin_map[1:0];
    m1 = pin_map[3:2];
    m2 = pin_map[5:4];
    m3 = pin_map[7:6];
    m4 = pin_map[9:8];
    m5 = pin_map[11:10];
    next_pins = 6'h00;
    dat  = packet_mode ? (rx_gate & rx_data_sel) : rx_data_sel;
    dclk = (op_mode == RSPF_TX) ? tx_bit_clk : (bs_on ? rec_clk : 1'b0);
    if (!packet_mode) begin
      case (op_mode)
        RSPF_SLEEP, RSPF_STDBY, RSPF_FS: begin
          next_pins[0] = pick(m0, op_mode == RSPF_FS & status.synth_locked, 1'b0,
                              status.low_supply_flag, status.mode_switch_done);
          next_pins[1] = pick(m1, 1'b0, 1'b0, status.low_supply_flag,
                              op_mode == RSPF_FS & status.synth_locked);
          next_pins[3] = pick(m3, 1'b0, 1'b0, status.auto_sequence_active, 1'b0);
          next_pins[4] = pick(m4, 1'b0, 1'b0, status.low_supply_flag,
                              op_mode == RSPF_FS & status.synth_locked);
          next_pins[5] = pick(m5, op_mode != RSPF_SLEEP & status.divided_clock_out, 1'b0,
                              status.low_supply_flag, status.mode_switch_done);
        end
        RSPF_RX: begin
          next_pins[0] = pick(m0, status.sync_match, status.rx_timeout, status.rssi_hit,
                              status.mode_switch_done);
          next_pins[1] = pick(m1, dclk, status.receiver_ready, status.low_supply_flag,
                              status.sync_match);
          next_pins[2] = dat;
          next_pins[3] = pick(m3, status.rssi_hit, status.receiver_ready,
                              status.auto_sequence_active, status.rx_timeout);
          next_pins[4] = pick(m4, status.rx_timeout, status.receiver_ready, status.sync_match,
                              status.synth_locked);
          next_pins[5] = pick(m5, status.divided_clock_out, status.rssi_hit,
                              status.low_supply_flag, status.mode_switch_done);
        end
        RSPF_TX: begin
          next_pins[0] = pick(m0, status.synth_locked, status.transmitter_ready,
                              status.low_supply_flag, status.mode_switch_done);
          next_pins[1] = pick(m1, dclk, status.transmitter_ready, status.low_supply_flag,
                              status.synth_locked);
          next_pins[3] = pick(m3, status.transmitter_ready, status.transmitter_ready,
                              status.auto_sequence_active, status.transmitter_ready);
          next_pins[4] = pick(m4, status.transmitter_ready, status.transmitter_ready,
                              status.low_supply_flag, status.synth_locked);
          next_pins[5] = pick(m5, status.divided_clock_out, status.divided_clock_out,
                              status.low_supply_flag, status.mode_switch_done);
        end
        default: next_pins = 6'h00;
      endcase
    end else begin
      next_pins[1] = pick(m1, status.queue_threshold_hit, status.queue_full,
                          status.queue_has_data, 1'b0);
      next_pins[2] = pick(m2, status.queue_has_data, 1'b0, status.low_supply_flag,
                          status.auto_sequence_active);
      next_pins[3] = pick(m3, status.queue_full, 1'b0, status.low_supply_flag, 1'b0);
      next_pins[4] = pick(m4, 1'b0, 1'b0, status.low_supply_flag, 1'b0);
      next_pins[5] = pick(m5, op_mode != RSPF_SLEEP & status.divided_clock_out, 1'b0,
                          status.low_supply_flag, status.mode_switch_done);
      case (op_mode)
        RSPF_SLEEP, RSPF_STDBY: begin
          next_pins[0] = pick(m0, 1'b0, 1'b0, status.low_supply_flag, 1'b0);
        end
        RSPF_FS: begin
          next_pins[0] = pick(m0, 1'b0, 1'b0, status.low_supply_flag, status.synth_locked);
          next_pins[1] = pick(m1, status.queue_threshold_hit, status.queue_full,
                              status.queue_has_data, status.synth_locked);
          next_pins[3] = pick(m3, status.queue_full, 1'b0, status.low_supply_flag,
                              status.synth_locked);
          next_pins[4] = pick(m4, 1'b0, 1'b0, status.low_supply_flag, status.synth_locked);
        end
        RSPF_RX: begin
          next_pins[0] = pick(m0, status.check_passed, status.payload_ready_a,
                              status.sync_match, status.rssi_hit);
          next_pins[1] = pick(m1, status.queue_threshold_hit, status.queue_full,
                              status.queue_has_data, status.rx_timeout);
          next_pins[2] = pick(m2, status.queue_has_data, dat, status.low_supply_flag,
                              status.auto_sequence_active);
          next_pins[3] = pick(m3, status.queue_full, status.rssi_hit, status.sync_match,
                              status.synth_locked);
          next_pins[4] = pick(m4, status.rx_timeout, status.rssi_hit, status.receiver_ready,
                              status.synth_locked);
          next_pins[5] = pick(m5, status.divided_clock_out, dat, status.low_supply_flag,
                              status.mode_switch_done);
        end
        RSPF_TX: begin
          next_pins[0] = pick(m0, status.packet_sent_b, status.transmitter_ready,
                              status.low_supply_flag, status.synth_locked);
          next_pins[1] = pick(m1, status.queue_threshold_hit, status.queue_full,
                              status.queue_has_data, status.synth_locked);
          next_pins[3] = pick(m3, status.queue_full, status.transmitter_ready,
                              status.low_supply_flag, status.synth_locked);
          next_pins[4] = pick(m4, status.mode_switch_done, status.transmitter_ready,
                              status.low_supply_flag, status.synth_locked);
        end
        default: next_pins = 6'h00;
      endcase
    end
  end

  // registered pins: one cycle latency, no glitches from the mux
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gp_pin_out  <= 6'h00;
      gp_pin_2_oe <= 1'b0;
    end else begin
      gp_pin_out <= next_pins;
      // pin2 turns round to an input only for continuous transmit
      gp_pin_2_oe <= !(op_mode == RSPF_TX && !packet_mode);
    end
  end

  // frame format decode and sanity of the programmed length
  always_comb begin
    frame_has_len_byte = 1'b0;
    frame_cfg_ok       = 1'b1;
    if (frame_cfg.frame_format_bit) begin
      frame_fmt          = RSPF_FMT_VARIABLE;
      frame_has_len_byte = 1'b1;
      // the length setting is the receive ceiling; it must admit two bytes
      if (frame_cfg.frame_length_setting + 9'h001 < {1'b0, `RSPF_VAR_MIN}) begin
        frame_cfg_ok = 1'b0;
      end
      if (frame_cfg.aes_on && frame_cfg.frame_length_setting >
          (frame_cfg.address_on ? `RSPF_AES_VAR_ADR : `RSPF_AES_MSG_MAX)) begin
        frame_cfg_ok = 1'b0;
      end
    end else if (frame_cfg.frame_length_setting != 8'h00) begin
      frame_fmt = RSPF_FMT_FIXED;
      if (frame_cfg.aes_on && frame_cfg.frame_length_setting >
          (frame_cfg.address_on ? `RSPF_AES_FIX_ADR : `RSPF_AES_MSG_MAX)) begin
        frame_cfg_ok = 1'b0;
      end
    end else begin
      frame_fmt = RSPF_FMT_UNLIMITED;
    end
  end

  chk_unused_low: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && op_mode == RSPF_SLEEP && pin_map[1:0] == `RSPF_MAP_00) |=> !gp_pin_out[0])
    else $error("unselected pin not low");
  chk_cont_sync: assert property (@(posedge sys_clk) disable iff (rst)
    (!packet_mode && op_mode == RSPF_RX && pin_map[1:0] == `RSPF_MAP_00)
    |=> gp_pin_out[0] == $past(status.sync_match))
    else $error("pin0 not sync match in continuous receive");
  chk_pkt_crc: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && op_mode == RSPF_RX && pin_map[1:0] == `RSPF_MAP_00)
    |=> gp_pin_out[0] == $past(status.check_passed))
    else $error("pin0 not check passed in packet receive");
  chk_pkt_sent: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && op_mode == RSPF_TX && pin_map[1:0] == `RSPF_MAP_00)
    |=> gp_pin_out[0] == $past(status.packet_sent_b))
    else $error("pin0 not packet sent in packet transmit");
  // mode and map are taken in the cycle the pins are computed, not the cycle they show
  chk_rx_window: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && !rx_gate && op_mode == RSPF_RX && pin_map[11:10] == `RSPF_MAP_01)
    |=> !gp_pin_out[5])
    else $error("receive data shown outside its window");
  chk_tx_sample: assert property (@(posedge sys_clk) disable iff (rst)
    mod_bit_valid |-> $past(tx_bit_clk) && !$past(tx_clk_q) && !$past(packet_mode)
    && $past(op_mode) == RSPF_TX)
    else $error("transmit bit taken off a rising clock edge");
  chk_pkt_bsync: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && op_mode == RSPF_RX) |-> bit_sync_active)
    else $error("synchronizer off in packet receive");
  chk_no_dclk: assert property (@(posedge sys_clk) disable iff (rst)
    (!packet_mode && !bit_sync_en && op_mode == RSPF_RX && pin_map[3:2] == `RSPF_MAP_00)
    [*2] |-> !gp_pin_out[1])
    else $error("clock shown without synchronizer");
  chk_fmt_fixed: assert property (@(posedge sys_clk) disable iff (rst)
    (!frame_cfg.frame_format_bit && frame_cfg.frame_length_setting != 8'h00)
    |-> frame_fmt == RSPF_FMT_FIXED && !frame_has_len_byte)
    else $error("fixed framing not decoded");
  chk_queue_sleep: assert property (@(posedge sys_clk) disable iff (rst)
    (packet_mode && queue_wr_req && op_mode == RSPF_SLEEP) |-> queue_wr_ok)
    else $error("queue write refused in sleep");

  cov_cont_tx: cover property (@(posedge sys_clk) disable iff (rst) mod_bit_valid);
  cov_rx_open: cover property (@(posedge sys_clk) disable iff (rst) $rose(rx_gate));
  cov_rx_shut: cover property (@(posedge sys_clk) disable iff (rst) $fell(rx_gate));
  cov_fmt_var: cover property (@(posedge sys_clk) disable iff (rst)
    frame_fmt == RSPF_FMT_VARIABLE && frame_cfg_ok);
endmodule : rspf_pin_mux
`default_nettype wire

/* rspf_pin_mux_tb_top.sv */
/* bench for the status pin mux: pin tables, continuous link, frame decode.
   assumes rspf_mcu_model on the pin side. */
`timescale 1ns/1ps
`default_nettype none
module rspf_pin_mux_tb_top;
  import rspf_pkg::*;
  logic            sys_clk, rst, packet_mode, bit_sync_en, demod_bit, tx_bit_clk, wr_req, pin2_wire, tx_bit;
  logic            queue_wr_ok, queue_rd_ok, handler_active, bit_sync_active, frame_has_len_byte, frame_cfg_ok;
  logic            gp_pin_2_oe, mod_bit, mod_bit_valid, seen, lk_d1, pin1_chk;
  logic [5:0]      gp;
  logic [11:0]     pin_map;
  logic [3:0]      lk_cnt;
  logic [7:0]      tx_half;
  rspf_mode_t      op_mode;
  rspf_status_t    status;
  rspf_frame_cfg_t frame_cfg;
  rspf_fmt_t       frame_fmt;
  logic            exp_q[$];
  int              error_cnt, n_tests;
  // format, length, aes, address -> one-hot format, length byte, cfg ok
  // each fixed row models a network whose nodes all share that one length
  logic [16:0] ftab [10] = '{{1'b0,8'h01,2'h0,4'h1,2'h1}, {1'b0,8'hff,2'h0,4'h1,2'h1},
    {1'b1,8'h05,2'h0,4'h2,2'h3}, {1'b0,8'h00,2'h0,4'h4,2'h1}, {1'b0,8'h41,2'h3,4'h1,2'h1},
    {1'b0,8'h41,2'h2,4'h1,2'h0}, {1'b0,8'h42,2'h3,4'h1,2'h0}, {1'b1,8'h42,2'h3,4'h2,2'h3},
    {1'b1,8'h43,2'h3,4'h2,2'h2}, {1'b1,8'h40,2'h2,4'h2,2'h3}};

  rspf_pin_mux rspf_pin_mux_inst (.sys_clk(sys_clk), .rst(rst), .op_mode(op_mode), .packet_mode(packet_mode),
    .bit_sync_en(bit_sync_en), .bit_half_period(8'h03), .pin_map(pin_map), .status(status),
    .frame_cfg(frame_cfg), .demod_bit(demod_bit), .tx_bit_clk(tx_bit_clk), .gp_pin_2_in(pin2_wire),
    .queue_wr_req(wr_req), .queue_rd_req(wr_req), .gp_pin_out(gp), .gp_pin_2_oe(gp_pin_2_oe),
    .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid), .queue_wr_ok(queue_wr_ok), .queue_rd_ok(queue_rd_ok),
    .handler_active(handler_active), .bit_sync_active(bit_sync_active), .frame_fmt(frame_fmt),
    .frame_has_len_byte(frame_has_len_byte), .frame_cfg_ok(frame_cfg_ok));
  rspf_mcu_model rspf_mcu_model_inst (.sys_clk(sys_clk), .rst(rst), .clk_pin(gp[1]), .dev_oe(gp_pin_2_oe),
    .dev_pin(gp[2]), .tx_bit(tx_bit), .pin2_wire(pin2_wire));

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic setup(input rspf_mode_t m, input logic pk, input logic [1:0] code);
    @(posedge sys_clk);
    op_mode <= m;
    packet_mode <= pk;
    pin_map <= {6{code}};
    status <= rspf_status_t'(16'($urandom));
    demod_bit <= 1'($urandom);
    wr_req <= 1'($urandom);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : setup

  // pin5 must stay low outside the receive window while data keeps moving
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      demod_bit <= 1'($urandom);
      @(negedge sys_clk);
      check(gp[5], 1'b0);
    end
  endtask : quiet

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = !sys_clk;
  end

  // link clock runs only during a transmit burst and stops low
  always @(posedge sys_clk) begin
    if (tx_half != 8'h00) begin
      lk_cnt <= lk_cnt + 4'h1;
      if (lk_cnt == 4'hf) begin
        tx_bit_clk <= !tx_bit_clk;
        tx_half <= tx_half - 8'h01;
        if (!tx_bit_clk) exp_q.push_back(tx_bit);
      end
    end
  end

  always @(posedge sys_clk) begin
    lk_d1 <= tx_bit_clk;
    if (pin1_chk) check(gp[1], lk_d1);
    if (mod_bit_valid === 1'b1) begin
      if (exp_q.size() == 0) check(8'h01, 8'h00);
      else check(mod_bit, exp_q.pop_front());
    end
  end

  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst = 1'b1; op_mode = RSPF_SLEEP; packet_mode = 1'b0; bit_sync_en = 1'b0; pin_map = 12'h000;
    status = '0; frame_cfg = '0; demod_bit = 1'b0; tx_bit_clk = 1'b0; wr_req = 1'b0;
    lk_cnt = 4'h0; tx_half = 8'h00; pin1_chk = 1'b0; error_cnt = 0; n_tests = 0;
    void'($urandom(32'h3d48));
    repeat (10) @(posedge sys_clk);
    check({gp, gp_pin_2_oe}, 8'h00);
    rst <= 1'b0;
    setup(RSPF_RX, 1'b0, 2'h0);
    check({gp[5:3], gp[0]}, {status.divided_clock_out, status.rx_timeout, status.rssi_hit, status.sync_match});
    check(gp[2:1], {demod_bit, 1'b0});
    setup(RSPF_SLEEP, 1'b0, 2'h0);
    check(gp, 8'h00);
    check({handler_active, bit_sync_active, queue_wr_ok}, 8'h00);
    setup(RSPF_RX, 1'b1, 2'h0);
    check(gp[3:0], {status.queue_full, status.queue_has_data, status.queue_threshold_hit, status.check_passed});
    check({handler_active, bit_sync_active}, 8'h03);
    setup(RSPF_RX, 1'b1, 2'h1);
    check(gp[0], status.payload_ready_a);
    setup(RSPF_TX, 1'b1, 2'h0);
    check(gp[0], status.packet_sent_b);
    for (int m = 0; m < 5; m++) begin
      setup(rspf_mode_t'(m), 1'b1, 2'h0);
      check({queue_wr_ok, queue_rd_ok}, {2{wr_req}});
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      frame_cfg <= ftab[i][16:6];
      @(negedge sys_clk);
      check({frame_fmt, frame_has_len_byte, frame_cfg_ok}, ftab[i][5:0]);
    end
    setup(RSPF_RX, 1'b1, 2'h1);
    @(posedge sys_clk);
    status <= '0;
    @(posedge sys_clk);
    status.payload_ready_a <= 1'b1;
    repeat (3) @(posedge sys_clk);
    status.payload_ready_a <= 1'b0;
    quiet(40);
    @(posedge sys_clk);
    status.receiver_ready <= 1'b1;
    demod_bit <= 1'b1;
    seen = 1'b0;
    repeat (64) begin
      @(negedge sys_clk);
      seen = seen | gp[5];
    end
    check(seen, 1'b1);
    @(posedge sys_clk);
    status.payload_ready_a <= 1'b1;
    repeat (3) @(posedge sys_clk);
    quiet(40);
    @(posedge sys_clk);
    bit_sync_en <= 1'b1;
    setup(RSPF_TX, 1'b0, 2'h0);
    check(gp_pin_2_oe, 1'b0);
    pin1_chk = 1'b1;
    tx_half <= 8'h14;
    repeat (700) @(posedge sys_clk);
    pin1_chk = 1'b0;
    check(8'(exp_q.size()), 8'h00);
    // continuous receive with the synchronizer on: recovered clock and clean data
    setup(RSPF_RX, 1'b0, 2'h0);
    seen = 1'b0;
    repeat (16) begin
      @(negedge sys_clk);
      seen = seen | gp[1];
    end
    check(seen, 1'b1);
    check(gp[2], demod_bit);
    end_of_test();
  end
endmodule : rspf_pin_mux_tb_top
`default_nettype wire

/* rspf_pkg.sv */
/*
  types of the radio status pin mux.
  assumes rspf_consts.svh beside it.
*/
`include "rspf_consts.svh"
package rspf_pkg;
  typedef enum logic [2:0] {
    RSPF_SLEEP = 3'h0,
    RSPF_STDBY = 3'h1,
    RSPF_FS    = 3'h2,
    RSPF_TX    = 3'h3,
    RSPF_RX    = 3'h4
  } rspf_mode_t;

  typedef enum logic [3:0] {
    RSPF_FMT_FIXED     = 4'b0001,
    RSPF_FMT_VARIABLE  = 4'b0010,
    RSPF_FMT_UNLIMITED = 4'b0100,
    RSPF_FMT_BAD       = 4'b1000
  } rspf_fmt_t;

  // internal status sources routed onto the pins
  typedef struct packed {
    logic low_supply_flag;
    logic auto_sequence_active;
    logic mode_switch_done;
    logic divided_clock_out;
    logic synth_locked;
    logic receiver_ready;
    logic transmitter_ready;
    logic sync_match;
    logic rssi_hit;
    logic rx_timeout;
    logic queue_full;
    logic queue_has_data;
    logic queue_threshold_hit;
    logic check_passed;
    logic payload_ready_a;
    logic packet_sent_b;
  } rspf_status_t;

  typedef struct packed {
    logic       frame_format_bit;
    logic [7:0] frame_length_setting;
    logic       aes_on;
    logic       address_on;
  } rspf_frame_cfg_t;
endpackage : rspf_pkg
